// >>> src/dsplr_pixel_mem.sv
// Pixel charge store for one section; read data leaves through a register.
module dsplr_pixel_mem #(
   parameter int unsigned DEPTH = 64,
   parameter int unsigned WIDTH = 8,
   parameter int unsigned AW    = 6
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_wr_en,
   input  wire logic [AW-1:0]    i_wr_addr,
   input  wire logic [WIDTH-1:0] i_wr_data,
   input  wire logic [AW-1:0]    i_rd_addr,
   output logic      [WIDTH-1:0] o_rd_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   // Storage has no reset; software-free pixels start in an unknown charge state.
   always_ff @(posedge i_sys_clk) begin
      if (i_wr_en) begin
         mem[i_wr_addr] <= i_wr_data;
      end
   end

   // Registered read keeps the output timing one clock behind the address.
   always_ff @(posedge i_sys_clk) begin
      o_rd_data <= mem[i_rd_addr];
   end

endmodule : dsplr_pixel_mem

// >>> src/dsplr_pkg.sv
package dsplr_pkg;

   // Geometry of the array: two sections of equal length.
   localparam int unsigned SECTION_PIXELS = 64;
   localparam int unsigned SECTION_COUNT  = 2;
   localparam int unsigned PIXEL_BITS     = 8;
   localparam int unsigned INDEX_BITS     = 6;

   // Pixel index of the first pixel of a section.
   localparam logic [INDEX_BITS-1:0] FIRST_PIXEL = 6'h00;

   // Clock figures, kept for the timing of the phase generator.
   localparam int unsigned SYS_CLK_MHZ = 125;
   localparam real         SYS_CLK_NS  = 8.0;

   // Phase generator outputs for one clock period.
   typedef struct packed {
      logic sense_reset;
      logic sample_track;
   } dsplr_phase_s;

   // One analog section output seen as a three-state digital sample bus.
   typedef struct packed {
      logic [PIXEL_BITS-1:0] level;
      logic                  drive_en;
   } dsplr_pixel_s;

endpackage : dsplr_pkg

// >>> src/dsplr_readout.sv
module dsplr_readout
   import dsplr_pkg::*;
#(
   parameter int unsigned PIXELS = dsplr_pkg::SECTION_PIXELS,
   parameter int unsigned PBITS  = dsplr_pkg::PIXEL_BITS
) (
   input  wire logic                              i_sys_clk,
   input  wire logic                              i_rst_n,
   input  wire logic                              i_start_in_first,
   input  wire logic                              i_start_in_second,
   input  wire logic [PBITS-1:0]                  i_light_first,
   input  wire logic [PBITS-1:0]                  i_light_second,
   output logic                                   o_carry_out_first,
   output logic                                   o_carry_out_second,
   output dsplr_pkg::dsplr_pixel_s                o_pixel_out_first,
   output dsplr_pkg::dsplr_pixel_s                o_pixel_out_second,
   output dsplr_pkg::dsplr_phase_s                o_phase_generator
);
   import dsplr_pkg::*;

   localparam int unsigned AW = $clog2(PIXELS);

   // Per-section signal bundles, indexed by section number.
   logic                  start_w    [SECTION_COUNT];
   logic [PBITS-1:0]      light_w    [SECTION_COUNT];
   logic                  carry_q    [SECTION_COUNT];
   dsplr_pixel_s          pix_q      [SECTION_COUNT];

   assign start_w[0] = i_start_in_first;
   assign start_w[1] = i_start_in_second;
   assign light_w[0] = i_light_first;
   assign light_w[1] = i_light_second;

   // The two sections share nothing but the clock and reset, so either hookup is set by board wiring.
   generate
      for (genvar s = 0; s < SECTION_COUNT; s++) begin : g_section
         logic [PIXELS-1:0] shift_q;
         logic              active_q;
         logic [AW-1:0]     index_q;
         logic              show_q;
         logic [PBITS-1:0]  rd_data;
         logic [PBITS-1:0]  charge_q;

         // The start pulse enters stage zero and walks one stage per clock.
         // A start during an active period is still shifted in, but the whole register clears on
         // an edge that finds the last stage set and no start; the controller keeps its pulses spaced instead.
         always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               shift_q <= '0;
            end else if (shift_q[PIXELS-1] && !start_w[s]) begin
               shift_q <= '0;
            end else begin
               shift_q <= {shift_q[PIXELS-2:0], start_w[s]};
            end
         end

         // Output period flag: raised by start, dropped on the edge after the last stage.
         always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               active_q <= 1'b0;
            end else if (start_w[s]) begin
               active_q <= 1'b1;
            end else if (shift_q[PIXELS-1]) begin
               active_q <= 1'b0;
            end
         end

         // Pixel index restarts at the first pixel and advances every edge while active.
         always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               index_q <= FIRST_PIXEL;
            end else if (start_w[s]) begin
               index_q <= FIRST_PIXEL;
            end else if (active_q) begin
               index_q <= index_q + 1'b1;
            end
         end

         // Carry leaves on the cycle the pulse sits in the last stage.
         always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               carry_q[s] <= 1'b0;
            end else begin
               carry_q[s] <= shift_q[PIXELS-2];
            end
         end

         // Charge is the light level registered on every edge; start plays no part.
         always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               charge_q <= '0;
            end else begin
               charge_q <= light_w[s];
            end
         end

         // Pixel store: each pixel is read and then refilled with fresh charge on the same
         // edge, so the next output period shows what was gathered since this one.
         // Writing only while active keeps the idle index from clobbering pixel zero.
         dsplr_pixel_mem #(
            .DEPTH (PIXELS),
            .WIDTH (PBITS),
            .AW    (AW)
         ) u_mem (
            .i_sys_clk (i_sys_clk),
            .i_wr_en   (active_q),
            .i_wr_addr (index_q),
            .i_wr_data (charge_q),
            .i_rd_addr (index_q),
            .o_rd_data (rd_data)
         );

         // Output drive delayed one clock to line up with the registered read.
         always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               show_q <= 1'b0;
            end else begin
               show_q <= active_q;
            end
         end

         // Sample-and-hold: level only changes on a clock edge, held in between.
         always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               pix_q[s] <= '0;
            end else begin
               pix_q[s].drive_en <= show_q;
               pix_q[s].level    <= show_q ? rd_data : '0;
            end
         end
      end
   endgenerate

   // Carries and pixel buses leave straight from their flops.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_carry_out_first  <= 1'b0;
         o_carry_out_second <= 1'b0;
         o_pixel_out_first  <= '0;
         o_pixel_out_second <= '0;
      end else begin
         o_carry_out_first  <= carry_q[0];
         o_carry_out_second <= carry_q[1];
         o_pixel_out_first  <= pix_q[0];
         o_pixel_out_second <= pix_q[1];
      end
   end

   // Phase generator: sense reset and tracking flag both toggling each cycle.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_phase_generator <= '0;
      end else begin
         o_phase_generator.sense_reset  <= ~o_phase_generator.sense_reset;
         o_phase_generator.sample_track <= ~o_phase_generator.sample_track;
      end
   end

endmodule : dsplr_readout

// >>> verification/dsplr_chk_sva.sv
module dsplr_chk (
   input wire logic                    i_sys_clk,
   input wire logic                    i_rst_n,
   input wire logic                    i_start_in_first,
   input wire logic                    i_start_in_second,
   input wire logic                    o_carry_out_first,
   input wire logic                    o_carry_out_second,
   input wire dsplr_pkg::dsplr_pixel_s o_pixel_out_first,
   input wire dsplr_pkg::dsplr_phase_s o_phase_generator
);
   timeunit 1ns;
   timeprecision 100ps;
   // All checks use the system clock and rest while reset is low.
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   property p_c1; i_start_in_first |-> ##65 o_carry_out_first; endproperty
   a_c1: assert property (p_c1) else $error("carry one late");
   property p_c2; i_start_in_second |-> ##65 o_carry_out_second; endproperty
   a_c2: assert property (p_c2) else $error("carry two late");
   property p_one; o_carry_out_first |=> !o_carry_out_first; endproperty
   a_one: assert property (p_one) else $error("carry too long");
   // Start taken at one edge shows as driven output four samples later.
   property p_go; i_start_in_first |-> ##4 o_pixel_out_first.drive_en; endproperty
   a_go: assert property (p_go) else $error("no first pixel");
   property p_len; $rose(o_pixel_out_first.drive_en) |->
      ##63 o_pixel_out_first.drive_en ##1 !o_pixel_out_first.drive_en; endproperty
   a_len: assert property (p_len) else $error("bad pixel count");
   property p_end; o_carry_out_first |-> o_pixel_out_first.drive_en; endproperty
   a_end: assert property (p_end) else $error("carry off last pixel");
   property p_hz; !o_pixel_out_first.drive_en |-> o_pixel_out_first.level == 8'h00; endproperty
   a_hz: assert property (p_hz) else $error("level while floating");
   // The sense reset phase must flip on every edge, in both directions.
   property p_sr; !o_phase_generator.sense_reset |=> o_phase_generator.sense_reset; endproperty
   a_sr: assert property (p_sr) else $error("sense reset missing");
   property p_sr_off; o_phase_generator.sense_reset |=> !o_phase_generator.sense_reset;
   endproperty
   a_sr_off: assert property (p_sr_off) else $error("sense reset stuck");
   // Parallel, serial and back-to-back starts are all reached.
   c_par: cover property (o_carry_out_first && o_carry_out_second);
   c_ser: cover property (i_start_in_second && !i_start_in_first);
   c_bk: cover property (i_start_in_first && o_pixel_out_first.drive_en);
endmodule : dsplr_chk

bind dsplr_readout dsplr_chk u_chk (.*);

// >>> verification/dsplr_host.sv
module dsplr_host (
   input wire logic i_sys_clk,
   input wire logic i_go,
   output logic     o_start = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   // Start copies the request one edge later, high for as many edges as it is held; the bench spaces requests.
   always @(posedge i_sys_clk) o_start <= i_go;
endmodule : dsplr_host

// >>> verification/dsplr_readout_test.sv
module dsplr_readout_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_sys_clk = 1'b0, i_rst_n = 1'b0, go = 1'b0, ser = 1'b0, st1, c1, c2;
   dsplr_pkg::dsplr_pixel_s p1, p2;
   int num_errors = 0, tests_run = 0, s[7];
   // Free-running system clock.
   initial forever #4 i_sys_clk = ~i_sys_clk;
   dsplr_host u_host (.i_sys_clk(i_sys_clk), .i_go(go), .o_start(st1));
   // Serial hookup feeds the first carry to the second start; light is fixed.
   dsplr_readout dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_start_in_first(st1),
      .i_start_in_second(ser ? c1 : st1), .i_light_first(8'h5a), .i_light_second(8'ha5),
      .o_carry_out_first(c1), .o_carry_out_second(c2), .o_pixel_out_first(p1),
      .o_pixel_out_second(p2), .o_phase_generator());
   task chk(input int got, input int exp);
      tests_run++;
      if (got !== exp) num_errors++;
      if (got !== exp) $display("ERROR %0t got %0d exp %0d", $time, got, exp);
   endtask : chk
   // Logs last carries, drive counts and first second-output drive, from edge 0 = start.
   task automatic run(input int rs);
      s = '{-1, -1, 0, 0, -1, 0, 0};
      @(posedge i_sys_clk) #1 go = 1'b1;
      @(posedge i_sys_clk) #1 go = 1'b0;
      for (int i = 0; i < 200; i++) begin
         @(posedge i_sys_clk) #1 go = (i == rs - 2);
         if (c1 === 1'b1) s[0] = i;
         if (c2 === 1'b1) s[1] = i;
         s[2] += (p1.drive_en === 1'b1);
         s[3] += (p2.drive_en === 1'b1);
         if (p2.drive_en === 1'b1 && s[4] < 0) s[4] = i;
         // Pixels refilled during an earlier period must carry the fixed light level.
         s[5] += (p1.drive_en === 1'b1 && p1.level === 8'h5a);
         s[6] += (p2.drive_en === 1'b1 && p2.level === 8'ha5);
      end
   endtask : run
   task t_par;
      ser = 1'b0;
      run(65);
      chk(s[0], 129);
      chk(s[1], 129);
      chk(s[2], 128);
      chk(s[3], 128);
      chk(s[5], 64);
      chk(s[6], 64);
      $display("parallel test done");
   endtask : t_par
   task t_ser;
      ser = 1'b1;
      run(0);
      chk(s[4], 68);
      chk(s[1], 129);
      chk(s[3], 64);
      chk(s[5], 64);
      chk(s[6], 64);
      $display("serial test done");
   endtask : t_ser
   task close_out(input int hang);
      num_errors += hang;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (8) @(posedge i_sys_clk);
      #1 i_rst_n = 1'b1;
      t_par();
      t_ser();
      close_out(0);
   end
   // The tests need about 420 cycles; long past that the run is hung.
   initial #20000 close_out(1);
endmodule : dsplr_readout_test
